/* design/sece_params.svh */
// Constants of the serial EEPROM command engine
`ifndef SECE_PARAMS_SVH
`define SECE_PARAMS_SVH
`define SECE_CLK_PERIOD_NS 10
`define SECE_TWR_MS 5
`define SECE_TWR_CYCLES ((`SECE_TWR_MS * 1000000) / `SECE_CLK_PERIOD_NS)
`define SECE_TYPE_MAIN 4'ha
`define SECE_TYPE_SPECIAL 4'hb
`define SECE_SUB_ADDR 3'h0
`define SECE_SEL_ID 2'h0
`define SECE_SEL_LOCK 2'h1
`define SECE_SEL_SERIAL 2'h2
`define SECE_LOCK_BIT 1
`define SECE_UNDEF_DATA 8'hff
`define SECE_REG_CTRL 12'h000
`define SECE_REG_STATUS 12'h004
`define SECE_REG_SERIAL0 12'h008
`define SECE_REG_SERIAL1 12'h00c
`define SECE_REG_SERIAL2 12'h010
`define SECE_REG_SERIAL3 12'h014
`define SECE_CTRL_RST 32'h00000001
`define SECE_SERIAL_RST 32'h00000000
`define SECE_ST_BUSY_BIT 0
`define SECE_ST_LOCK_BIT 1
`define SECE_ST_ACTIVE_BIT 2
`define SECE_ST_PTR_LSB 16
`endif

/* design/sece_pkg.sv */
// Types of the serial EEPROM command engine
package sece_pkg;
  typedef struct packed {
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    logic sda;
  } sece_ev_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RX = 3'b001,
    ST_RXACK_WAIT = 3'b010,
    ST_RXACK = 3'b011,
    ST_TX = 3'b100,
    ST_TXACK = 3'b101,
    ST_BUSY = 3'b110
  } sece_state_t;
  typedef enum logic [1:0] {
    K_DEV = 2'b00,
    K_AHI = 2'b01,
    K_ALO = 2'b10,
    K_DATA = 2'b11
  } sece_kind_t;
endpackage

/* design/sece_pin_sync.sv */
// Pin synchroniser and bus event detector
`timescale 1ns/100ps
`default_nettype none
module sece_pin_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic scl_pin,
  input wire logic sda_pin,
  output sece_pkg::sece_ev_t ev
);
  import sece_pkg::*;
  logic scl_s1, scl_s2, scl_q;
  logic sda_s1, sda_s2, sda_q;

  // Idle bus level is high, so reset to one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_q <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_s1 <= scl_pin;
      scl_s2 <= scl_s1;
      scl_q <= scl_s2;
      sda_s1 <= sda_pin;
      sda_s2 <= sda_s1;
      sda_q <= sda_s2;
    end
  end

  always_comb begin
    ev.scl_rise = scl_s2 & ~scl_q;
    ev.scl_fall = ~scl_s2 & scl_q;
    ev.start = scl_s2 & scl_q & sda_q & ~sda_s2;
    ev.stop = scl_s2 & scl_q & ~sda_q & sda_s2;
    ev.sda = sda_s2;
  end
endmodule
`default_nettype wire

/* design/sece_engine.sv */
// Command engine of a two-wire serial EEPROM target with APB control
`timescale 1ns/100ps
`default_nettype none
`include "sece_params.svh"
module sece_engine #(
  parameter int unsigned WR_CYCLES = `SECE_TWR_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe
);
  import sece_pkg::*;

  sece_ev_t ev;
  sece_state_t state;
  sece_kind_t kind;
  logic [3:0] cnt;
  logic [7:0] shift;
  logic [7:0] byte_v;
  logic [11:0] ptr;
  logic [1:0] sel;
  logic special;
  logic rd_mode;
  logic ack_ok;
  logic go_tx;
  logic mack;
  logic wr_pending;
  logic lock_pending;
  logic locked;
  logic [18:0] busy_cnt;
  logic byte_done;
  logic dev_match;
  logic mem_we;
  logic id_we;
  logic [7:0] tx_byte;
  logic [31:0] ctrl;
  logic [31:0] serial [0:3];
  logic [7:0] mem [0:4095];
  logic [7:0] idpage [0:31];
  logic apb_setup;
  logic apb_wr;
  logic [2:0] rd_idx;
  logic [2:0] wr_idx;

  sece_pin_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .scl_pin(scl_in),
    .sda_pin(sda_in),
    .ev(ev)
  );

  // Register index, 3'h7 for unmapped or unaligned addresses
  function automatic logic [2:0] reg_idx(input logic [11:0] a);
    case (a)
      `SECE_REG_CTRL: reg_idx = 3'h0;
      `SECE_REG_STATUS: reg_idx = 3'h1;
      `SECE_REG_SERIAL0: reg_idx = 3'h2;
      `SECE_REG_SERIAL1: reg_idx = 3'h3;
      `SECE_REG_SERIAL2: reg_idx = 3'h4;
      `SECE_REG_SERIAL3: reg_idx = 3'h5;
      default: reg_idx = 3'h7;
    endcase
  endfunction

  // Special regions and page writes only move the low five bits
  function automatic logic [11:0] next_ptr(input logic [11:0] p,
                                           input logic in_page);
    if (in_page) begin
      next_ptr = {p[11:5], p[4:0] + 5'h01};
    end else begin
      next_ptr = p + 12'h001;
    end
  endfunction

  assign byte_v = {shift[6:0], ev.sda};
  assign byte_done = ev.scl_rise && state == ST_RX && cnt == 4'h7;
  assign dev_match = ctrl[0] && byte_v[3:1] == `SECE_SUB_ADDR &&
                     (byte_v[7:4] == `SECE_TYPE_MAIN ||
                      byte_v[7:4] == `SECE_TYPE_SPECIAL);
  assign mem_we = byte_done && kind == K_DATA && !special;
  assign id_we = byte_done && kind == K_DATA && special &&
                 sel == `SECE_SEL_ID && !locked;

  // Read source; the pointer is shared by every region
  always_comb begin
    tx_byte = mem[ptr];
    if (special) begin
      case (sel)
        `SECE_SEL_ID: tx_byte = idpage[ptr[4:0]];
        `SECE_SEL_SERIAL: begin
          if (ptr[4]) begin
            tx_byte = 8'h00;
          end else begin
            tx_byte = serial[ptr[3:2]][{ptr[1:0], 3'h0} +: 8];
          end
        end
        default: tx_byte = `SECE_UNDEF_DATA;
      endcase
    end
  end

  // Arrays hold no reset, like the real storage
  always_ff @(posedge pclk) begin
    if (mem_we) begin
      mem[ptr] <= byte_v;
    end
    if (id_we) begin
      idpage[ptr[4:0]] <= byte_v;
    end
  end

  // Bit and byte sequencing on the two-wire link
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      kind <= K_DEV;
      cnt <= 4'h0;
      shift <= 8'h00;
      ptr <= 12'h000;
      sel <= `SECE_SEL_SERIAL;
      special <= 1'b0;
      rd_mode <= 1'b0;
      ack_ok <= 1'b0;
      go_tx <= 1'b0;
      mack <= 1'b0;
      wr_pending <= 1'b0;
      lock_pending <= 1'b0;
      locked <= 1'b0;
      busy_cnt <= 19'h00000;
      sda_oe <= 1'b0;
    end else if (state == ST_BUSY) begin
      sda_oe <= 1'b0;
      if (busy_cnt == 19'h00000) begin
        state <= ST_IDLE;
        wr_pending <= 1'b0;
        if (lock_pending) begin
          locked <= 1'b1;
        end
        lock_pending <= 1'b0;
      end else begin
        busy_cnt <= busy_cnt - 19'h00001;
      end
    end else if (ev.stop) begin
      sda_oe <= 1'b0;
      if (wr_pending || lock_pending) begin
        state <= ST_BUSY;
        busy_cnt <= WR_CYCLES[18:0] - 19'h00001;
      end else begin
        state <= ST_IDLE;
      end
    end else if (ev.start) begin
      // Repeated START also lands here, keeping the loaded pointer
      sda_oe <= 1'b0;
      state <= ST_RX;
      kind <= K_DEV;
      cnt <= 4'h0;
    end else begin
      case (state)
        ST_RX: begin
          if (ev.scl_rise) begin
            shift <= byte_v;
            cnt <= cnt + 4'h1;
          end
          if (byte_done) begin
            state <= ST_RXACK_WAIT;
            go_tx <= 1'b0;
            ack_ok <= 1'b1;
            case (kind)
              K_DEV: begin
                ack_ok <= dev_match;
                special <= byte_v[7:4] == `SECE_TYPE_SPECIAL;
                rd_mode <= byte_v[0];
                go_tx <= byte_v[0];
                kind <= K_AHI;
              end
              K_AHI: begin
                ptr[11:8] <= byte_v[3:0];
                sel <= byte_v[3:2];
                kind <= K_ALO;
              end
              K_ALO: begin
                ptr[7:0] <= byte_v;
                kind <= K_DATA;
              end
              default: begin
                if (!special) begin
                  wr_pending <= 1'b1;
                  ptr <= next_ptr(ptr, 1'b1);
                end else begin
                  case (sel)
                    `SECE_SEL_ID: begin
                      ack_ok <= !locked;
                      if (!locked) begin
                        wr_pending <= 1'b1;
                        ptr <= next_ptr(ptr, 1'b1);
                      end
                    end
                    `SECE_SEL_LOCK: begin
                      ack_ok <= !locked;
                      if (!locked && byte_v[`SECE_LOCK_BIT]) begin
                        lock_pending <= 1'b1;
                      end
                    end
                    default: ack_ok <= 1'b0;
                  endcase
                end
              end
            endcase
          end
        end
        ST_RXACK_WAIT: begin
          if (ev.scl_fall) begin
            sda_oe <= ack_ok;
            state <= ST_RXACK;
          end
        end
        ST_RXACK: begin
          if (ev.scl_fall) begin
            cnt <= 4'h0;
            if (!ack_ok) begin
              sda_oe <= 1'b0;
              state <= ST_IDLE;
            end else if (go_tx) begin
              shift <= tx_byte;
              sda_oe <= !tx_byte[7];
              ptr <= next_ptr(ptr, special);
              cnt <= 4'h1;
              state <= ST_TX;
            end else begin
              sda_oe <= 1'b0;
              state <= ST_RX;
            end
          end
        end
        ST_TX: begin
          if (ev.scl_fall) begin
            if (cnt == 4'h8) begin
              sda_oe <= 1'b0;
              state <= ST_TXACK;
            end else begin
              sda_oe <= !shift[3'h7 - cnt[2:0]];
              cnt <= cnt + 4'h1;
            end
          end
        end
        ST_TXACK: begin
          if (ev.scl_rise) begin
            mack <= !ev.sda;
          end
          if (ev.scl_fall) begin
            if (mack) begin
              shift <= tx_byte;
              sda_oe <= !tx_byte[7];
              ptr <= next_ptr(ptr, special);
              cnt <= 4'h1;
              state <= ST_TX;
            end else begin
              sda_oe <= 1'b0;
              state <= ST_IDLE;
            end
          end
        end
        default: begin
          sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // Open drain: the line is only ever pulled low
  assign sda_out = 1'b0;

  // APB slave, zero wait states
  assign pready = 1'b1;
  assign apb_setup = psel && !penable;
  assign apb_wr = psel && penable && pwrite;
  assign rd_idx = reg_idx(paddr);
  assign wr_idx = reg_idx(paddr);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (apb_setup) begin
      pslverr <= rd_idx == 3'h7;
      prdata <= 32'h00000000;
      case (rd_idx)
        3'h0: prdata <= ctrl;
        3'h1: begin
          prdata[`SECE_ST_BUSY_BIT] <= state == ST_BUSY;
          prdata[`SECE_ST_LOCK_BIT] <= locked;
          prdata[`SECE_ST_ACTIVE_BIT] <= state != ST_IDLE &&
                                         state != ST_BUSY;
          prdata[`SECE_ST_PTR_LSB +: 12] <= ptr;
        end
        3'h2: prdata <= serial[0];
        3'h3: prdata <= serial[1];
        3'h4: prdata <= serial[2];
        3'h5: prdata <= serial[3];
        default: prdata <= 32'h00000000;
      endcase
    end
  end

  // Serial number is loaded by software, read-only to the link
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `SECE_CTRL_RST;
      for (int i = 0; i < 4; i++) begin
        serial[i] <= `SECE_SERIAL_RST;
      end
    end else if (apb_wr) begin
      if (wr_idx == 3'h0) begin
        ctrl <= {31'h00000000, pwdata[0]};
      end
      for (int i = 0; i < 4; i++) begin
        if (wr_idx == 3'(i + 2)) begin
          serial[i] <= pwdata;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* tb/sece_sva.sv */
// Port checker for the serial EEPROM command engine
`timescale 1ns/100ps
`default_nettype none
module sece_sva #(
  parameter int unsigned WR_CYCLES = 20
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence bad_s;
    setup_s ##0 (paddr[1:0] != 2'h0 || paddr > 12'h014);
  endsequence
  a_ready_zero: assert property (setup_s |=> pready) // Zero wait states
    else $error("pready low in access phase");
  a_err_cause: assert property (bad_s ##1 penable |-> pslverr) // Unmapped
    else $error("unmapped access without pslverr");
  a_err_phase: assert property ($rose(pslverr) |-> psel && penable) // Access
    else $error("pslverr outside access phase");
  a_err_zero: assert property (pslverr |-> prdata == 32'h0) // Refused read
    else $error("refused read data not zero");
  a_open_drain: assert property (!sda_out)
    else $error("data line driven high");
  a_oe_stable: assert property (
    scl_in && $past(scl_in) |-> $stable(sda_oe))
    else $error("data line changed while clock high");
  a_oe_hold: assert property ($rose(sda_oe) |-> sda_oe [*6])
    else $error("low bit shorter than a clock period");
  a_oe_low_rise: assert property ($rose(sda_oe) |-> !scl_in)
    else $error("data line pulled while clock high");
  a_reset_quiet: assert property ($rose(presetn) |-> !sda_oe && !pslverr)
    else $error("outputs active after reset");
endmodule
bind sece_engine sece_sva #(.WR_CYCLES(WR_CYCLES)) sva_u (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .scl_in, .sda_in, .sda_out, .sda_oe);
`default_nettype wire

/* tb/sece_bus_master.sv */
// Two-wire bus master model; clock high 30 ns, low 50 ns
`timescale 1ns/100ps
`default_nettype none
module sece_bus_master (
  output logic scl,
  output logic sda_drive,
  input wire logic sda
);
  initial begin
    scl = 1'b1;
    sda_drive = 1'b0;
  end
  task automatic put_bit(input logic b);
    #10 sda_drive = !b;
    #40 scl = 1'b1;
    #30 scl = 1'b0;
  endtask
  task automatic get_bit(output logic b);
    sda_drive = 1'b0;
    #50 scl = 1'b1;
    #15 b = sda;
    #15 scl = 1'b0;
  endtask
  // Raises the clock with data released, then pulls data low while the clock is high
  task automatic start();
    sda_drive = 1'b0;
    #50 scl = 1'b1;
    #25 sda_drive = 1'b1;
    #25 scl = 1'b0;
  endtask
  task automatic stop();
    #10 sda_drive = 1'b1;
    #40 scl = 1'b1;
    #20 sda_drive = 1'b0;
    #40;
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) put_bit(d[i]);
    get_bit(b);
    ack = !b;
  endtask
  task automatic rbyte(input logic more, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) get_bit(d[i]);
    put_bit(!more);
  endtask
endmodule
`default_nettype wire

/* tb/test_serial_eeprom_cmd_engine.sv */
// Self-checking bench for the serial EEPROM command engine
`timescale 1ns/100ps
`default_nettype none
module test_serial_eeprom_cmd_engine;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, sda_oe, sda_out, scl, m_drive, k, e;
  wire sda;
  int n_errors = 0;
  int comparisons = 0;
  int cyc = 0;
  logic [31:0] seed = 32'h4ac7;
  logic [31:0] r;
  logic [11:0] a;
  logic [7:0] mem [0:4095];
  logic [7:0] idp [0:31];
  logic [7:0] ser [0:15];
  logic [7:0] rb [0:39];
  // Open drain line with pull-up
  assign sda = ~(sda_oe | m_drive);
  always #5 pclk = ~pclk;
  sece_engine #(.WR_CYCLES(300)) dut_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe));
  sece_bus_master bus_u (.scl(scl), .sda_drive(m_drive), .sda(sda));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [11:0] pinc(input logic [11:0] x);
    return {x[11:5], x[4:0] + 5'd1};
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("Comparisons %0d, errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] ad,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic hdr(input logic [7:0] dv, input logic [11:0] ad);
    bus_u.start();
    bus_u.wbyte(dv, k);
    check(k, 1);
    bus_u.wbyte({4'h0, ad[11:8]}, k);
    check(k, 1);
    bus_u.wbyte(ad[7:0], k);
    check(k, 1);
  endtask
  task automatic rd(input logic [7:0] dv, input int n);
    bus_u.start();
    bus_u.wbyte(dv, k);
    check(k, 1);
    for (int i = 0; i < n; i++) bus_u.rbyte(i < n - 1, rb[i]);
    bus_u.stop();
  endtask
  // First poll lands inside the write cycle
  task automatic poll();
    int t;
    t = 0;
    do begin
      bus_u.start();
      bus_u.wbyte(8'ha0, k);
      bus_u.stop();
      if (t == 0) check(k, 0);
      t++;
    end while (!k && t < 12);
    check(k, 1);
  endtask
  task automatic wr(input logic [7:0] dv, input logic [11:0] ad, input int n,
                    input logic ok);
    hdr(dv, ad);
    for (int i = 0; i < n; i++) begin
      seed = lfsr(seed);
      bus_u.wbyte(seed[7:0], k);
      check(k, ok);
      if (dv == 8'ha0) mem[ad] = seed[7:0];
      else if (ok) idp[ad[4:0]] = seed[7:0];
      ad = pinc(ad);
    end
    bus_u.stop();
    if (ok) poll();
  endtask
  task automatic vrd(input logic [7:0] dv, input logic [11:0] ad, input int n);
    hdr(dv, ad);
    rd(dv | 8'h01, n);
    for (int i = 0; i < n; i++) begin
      if (dv == 8'ha0) check(rb[i], mem[ad]);
      else check(rb[i], idp[ad[4:0]]);
      ad = (dv == 8'ha0) ? ad + 12'h1 : pinc(ad);
    end
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      conclude();
    end
  end
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    apb(0, 12'h000, 0);
    check(r, 32'h1);
    apb(0, 12'h018, 0);
    check(e, 1);
    check(r, 32'h0);
    apb(0, 12'h006, 0);
    check(e, 1);
    check(r, 32'h0);
    // Disabled device must not answer its own address
    apb(1, 12'h000, 0);
    bus_u.start();
    bus_u.wbyte(8'ha0, k);
    check(k, 0);
    bus_u.stop();
    apb(1, 12'h000, 1);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      apb(1, 12'h008 + 12'(4 * i), seed);
      apb(0, 12'h008 + 12'(4 * i), 0);
      check(r, seed);
      for (int j = 0; j < 4; j++) ser[4 * i + j] = seed[8 * j +: 8];
    end
    a = seed[11:0];
    wr(8'ha0, a, 1, 1);
    vrd(8'ha0, a, 1);
    a = {seed[11:5], 5'd30};
    wr(8'ha0, a, 4, 1);
    vrd(8'ha0, {a[11:5], 5'd0}, 2);
    vrd(8'ha0, a, 2);
    wr(8'ha0, 12'hfff, 1, 1);
    wr(8'ha0, 12'h000, 2, 1);
    vrd(8'ha0, 12'hfff, 2);
    rd(8'ha1, 1);
    check(rb[0], mem[1]);
    bus_u.start();
    bus_u.wbyte(8'h90, k);
    check(k, 0);
    bus_u.stop();
    wr(8'hb0, 12'h003, 3, 1);
    vrd(8'hb0, 12'h003, 3);
    wr(8'hb0, 12'h01f, 1, 1);
    hdr(8'hb0, 12'h400);
    bus_u.wbyte(8'h02, k);
    check(k, 1);
    bus_u.stop();
    poll();
    apb(0, 12'h004, 0);
    check(r[1], 1);
    wr(8'hb0, 12'h003, 2, 0);
    vrd(8'hb0, 12'h003, 3);
    hdr(8'hb0, 12'h800);
    rd(8'hb1, 34);
    for (int i = 0; i < 34; i++)
      check(rb[i], i < 16 ? ser[i] :
            (i < 32 ? 8'h00 : ser[i - 32]));
    rd(8'hb1, 1);
    check(rb[0], ser[2]);
    conclude();
  end
endmodule
`default_nettype wire
